// ### src/eau_pkg.sv
`default_nettype none
package eau_pkg;
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_INT_EN = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_INT_CLR = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_LAST_ADDR = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_LAST_OFFSET = 8'h14;
  localparam int CTRL_W = 2;
  localparam int CTRL_REAL_BIT = 0;
  localparam int CTRL_DSIZE_BIT = 1;
  // Core comes out of reset in real mode
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h1;
  localparam int EV_W = 2;
  localparam int EV_GP = 0;
  localparam int EV_FORM = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] REAL_LIMIT = 32'h0000ffff;
  localparam logic [2:0] NUM_BASE_B = 3'h3;
  localparam logic [2:0] NUM_STACK_PTR = 3'h4;
  localparam logic [2:0] NUM_FRAME = 3'h5;
  localparam logic [2:0] NUM_SRC_IDX = 3'h6;
  localparam logic [2:0] NUM_DEST_IDX = 3'h7;
  localparam int SEG_SHIFT = 4;
  localparam int PORT_W = 16;
  typedef enum logic [1:0] {DISP_NONE, DISP_BYTE, DISP_WIDE} eau_disp_type;
  typedef enum logic {ST_IDLE, ST_EXTRA} eau_state_type;
endpackage
`default_nettype wire

// ### src/eau_top.sv
// Chosen here: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module eau_top
  import eau_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus, write address
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Register bus, write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Register bus, write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus, read address
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Register bus, read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Address request from the decoder
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_io,
  input wire logic req_use_base,
  input wire logic req_use_index,
  input wire logic [2:0] req_base_num,
  input wire logic [2:0] req_index_num,
  input wire logic [31:0] req_base_value,
  input wire logic [31:0] req_index_value,
  input wire logic [1:0] req_scale,
  input wire eau_disp_type req_disp_kind,
  input wire logic [31:0] req_disp,
  input wire logic req_opsize_pfx,
  input wire logic req_asize_pfx,
  input wire logic [15:0] req_seg_sel,
  input wire logic [31:0] req_seg_base,
  input wire logic [7:0] req_port_imm,
  input wire logic req_port_from_reg,
  input wire logic [PORT_W-1:0] req_port_data_reg,
  // Result towards the bus interface
  output logic res_valid,
  output logic [31:0] res_offset,
  output logic [31:0] res_addr,
  output logic res_mem_io_sel,
  output logic res_gp_fault,
  output logic res_form_fault,
  output logic res_opsize32,
  output logic res_addrsize32,
  // Interrupt
  output logic irq
);

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_INT_EN) ||
             (a == OFS_INT_CLR) || (a == OFS_LAST_ADDR) || (a == OFS_LAST_OFFSET);
  endfunction

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_got_ff, w_got_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [EV_W-1:0] status_ff, int_en_ff, nxt_status;
  logic irq_ff;
  eau_state_type state_ff;
  logic req_ready_ff, res_valid_ff, mem_io_ff, gp_ff, form_ff;
  logic op32_ff, a32_ff, res_real_ff;
  logic [31:0] res_offset_ff, res_addr_ff;

  logic aw_hs, w_hs, ar_hs, wr_do, acc;
  logic real_c, dflt_c, a32_c, o32_c, both_c, form_bad_c, gp_c;
  logic [31:0] base_c, scaled_c, disp_c, sum_c, off_c, addr_c;
  logic [PORT_W-1:0] port_c;
  logic [EV_W-1:0] clr_vec, set_vec;

  assign aw_hs = s_axi_awvalid && awready_ff;
  assign w_hs = s_axi_wvalid && wready_ff;
  assign ar_hs = s_axi_arvalid && arready_ff;
  assign wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
  assign acc = req_valid && req_ready_ff;

  // Write address and data are captured independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
      awready_ff <= 1'b0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      else if (wr_do)
        aw_got_ff <= 1'b0;
      awready_ff <= !aw_got_ff && !aw_hs && !bvalid_ff && !wr_do;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      wready_ff <= 1'b0;
    end
    else
    begin
      if (w_hs)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      else if (wr_do)
        w_got_ff <= 1'b0;
      wready_ff <= !w_got_ff && !w_hs && !bvalid_ff && !wr_do;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (wr_do)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  // All writable fields live in byte lane 0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= CTRL_RESET;
      int_en_ff <= '0;
    end
    else if (wr_do && wstrb_ff[0])
    begin
      if (awaddr_ff == OFS_CTRL)
        ctrl_ff <= wdata_ff[CTRL_W-1:0];
      if (awaddr_ff == OFS_INT_EN)
        int_en_ff <= wdata_ff[EV_W-1:0];
    end
  end

  always_comb
  begin
    clr_vec = '0;
    if (wr_do && wstrb_ff[0] && awaddr_ff == OFS_INT_CLR)
      clr_vec = wdata_ff[EV_W-1:0];
    set_vec = '0;
    set_vec[EV_GP] = res_valid_ff && gp_ff;
    set_vec[EV_FORM] = res_valid_ff && form_ff;
    // A fault in the clearing cycle survives the clear
    nxt_status = (status_ff & ~clr_vec) | set_vec;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & int_en_ff);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
    end
    else
    begin
      arready_ff <= !ar_hs && !rvalid_ff;
      if (ar_hs)
      begin
        rvalid_ff <= 1'b1;
        rresp_ff <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr)
          OFS_CTRL: rdata_ff <= {{(32-CTRL_W){1'b0}}, ctrl_ff};
          OFS_STATUS: rdata_ff <= {{(32-EV_W){1'b0}}, status_ff};
          OFS_INT_EN: rdata_ff <= {{(32-EV_W){1'b0}}, int_en_ff};
          OFS_LAST_ADDR: rdata_ff <= res_addr_ff;
          OFS_LAST_OFFSET: rdata_ff <= res_offset_ff;
          default: rdata_ff <= '0;
        endcase
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  always_comb
  begin
    real_c = ctrl_ff[CTRL_REAL_BIT];
    dflt_c = real_c ? 1'b0 : ctrl_ff[CTRL_DSIZE_BIT];
    a32_c = dflt_c ^ req_asize_pfx;
    o32_c = dflt_c ^ req_opsize_pfx;
    base_c = req_use_base ? req_base_value : '0;
    scaled_c = '0;
    if (req_use_index)
      scaled_c = a32_c ? (req_index_value << req_scale) : req_index_value;
    unique case (req_disp_kind)
      DISP_NONE: disp_c = '0;
      DISP_BYTE: disp_c = {{24{req_disp[7]}}, req_disp[7:0]};
      DISP_WIDE: disp_c = a32_c ? req_disp : {{16{req_disp[15]}}, req_disp[15:0]};
      default: disp_c = '0;
    endcase
    sum_c = base_c + scaled_c + disp_c;
    off_c = a32_c ? sum_c : {16'h0000, sum_c[15:0]};
    if (a32_c)
      form_bad_c = req_use_index && req_index_num == NUM_STACK_PTR;
    else
      form_bad_c = (req_use_base && req_base_num != NUM_BASE_B && req_base_num != NUM_FRAME) ||
                   (req_use_index && req_index_num != NUM_SRC_IDX &&
                    req_index_num != NUM_DEST_IDX);
    form_bad_c = form_bad_c && !req_io;
    gp_c = !req_io && real_c && off_c > REAL_LIMIT;
    port_c = req_port_from_reg ? req_port_data_reg : {8'h00, req_port_imm};
    if (req_io)
      addr_c = {16'h0000, port_c};
    else if (real_c)
      addr_c = (32'(req_seg_sel) << SEG_SHIFT) + off_c;
    else
      addr_c = req_seg_base + off_c;
    both_c = !req_io && req_use_base && req_use_index;
  end

  // extra clock only for base plus index
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_IDLE;
      req_ready_ff <= 1'b0;
      res_valid_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (acc && both_c)
            state_ff <= ST_EXTRA;
        end
        ST_EXTRA:
          state_ff <= ST_IDLE;
      endcase
      req_ready_ff <= !(acc && both_c);
      res_valid_ff <= (acc && !both_c) || state_ff == ST_EXTRA;
    end
  end

  // Results are held until the next request so the bus side can sample late
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      res_offset_ff <= '0;
      res_addr_ff <= '0;
      mem_io_ff <= 1'b1;
      gp_ff <= 1'b0;
      form_ff <= 1'b0;
      op32_ff <= 1'b0;
      a32_ff <= 1'b0;
      res_real_ff <= 1'b0;
    end
    else if (acc)
    begin
      res_offset_ff <= req_io ? {16'h0000, port_c} : off_c;
      res_addr_ff <= addr_c;
      mem_io_ff <= !req_io;
      gp_ff <= gp_c;
      form_ff <= form_bad_c;
      op32_ff <= o32_c;
      a32_ff <= a32_c;
      res_real_ff <= real_c;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign req_ready = req_ready_ff;
  assign res_valid = res_valid_ff;
  assign res_offset = res_offset_ff;
  assign res_addr = res_addr_ff;
  assign res_mem_io_sel = mem_io_ff;
  assign res_gp_fault = gp_ff;
  assign res_form_fault = form_ff;
  assign res_opsize32 = op32_ff;
  assign res_addrsize32 = a32_ff;
  assign irq = irq_ff;

  // Checking helpers, multiply form kept apart from the shift datapath
  logic [31:0] chk_mult, chk_sum;
  logic exp_a32, exp_o32;
  assign chk_mult = 32'h1 << req_scale;
  assign chk_sum = req_base_value + req_index_value * chk_mult + disp_c;
  assign exp_a32 = ctrl_ff[CTRL_DSIZE_BIT] ^ req_asize_pfx;
  assign exp_o32 = ctrl_ff[CTRL_DSIZE_BIT] ^ req_opsize_pfx;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_extra_clock: assert property (
    acc && both_c |=> !res_valid_ff && !req_ready_ff ##1 res_valid_ff && req_ready_ff)
    else $error("base plus index did not take exactly one extra clock");
  a_no_extra: assert property (
    acc && !both_c |=> res_valid_ff)
    else $error("simple address took extra clocks");
  a_scaled_sum: assert property (
    acc && both_c && a32_c |-> ##2 res_offset_ff == $past(chk_sum, 2))
    else $error("scaled index sum wrong");
  a_size_prefix: assert property (
    acc && !real_c && !both_c |=> a32_ff == $past(exp_a32) && op32_ff == $past(exp_o32))
    else $error("size default or prefix inversion wrong");
  a_real_default: assert property (
    acc && real_c && !req_asize_pfx && !req_opsize_pfx
    |-> ##[1:2] res_valid_ff && !a32_ff && !op32_ff)
    else $error("real mode default is not 16 bits");
  a_real_limit: assert property (
    res_valid_ff && mem_io_ff && res_real_ff |-> gp_ff == (res_offset_ff > REAL_LIMIT))
    else $error("real mode limit fault wrong");
  a_wrap_16: assert property (
    res_valid_ff && mem_io_ff && !a32_ff |-> res_offset_ff[31:16] == 16'h0000)
    else $error("16-bit offset not wrapped");
  a_sp_index: assert property (
    acc && !req_io && a32_c && req_use_index && req_index_num == NUM_STACK_PTR
    |-> ##[1:2] res_valid_ff && form_ff)
    else $error("stack pointer index not flagged");
  a_io_select: assert property (
    acc && req_io |=> res_valid_ff && !mem_io_ff && res_addr_ff[31:16] == 16'h0000)
    else $error("port access select or upper lines wrong");
  a_port_imm: assert property (
    acc && req_io && !req_port_from_reg |=> res_addr_ff == {24'h000000, $past(req_port_imm)})
    else $error("immediate port address wrong");
  a_real_linear: assert property (
    acc && real_c && !req_io && !both_c
    |=> res_addr_ff == (32'($past(req_seg_sel)) << SEG_SHIFT) + res_offset_ff)
    else $error("real mode linear address wrong");

endmodule
`default_nettype wire

// ### dv/eau_bus_model.sv
`default_nettype none
module eau_bus_model
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Result from the address unit
  input wire logic res_valid,
  input wire logic [31:0] res_offset,
  input wire logic [31:0] res_addr,
  input wire logic res_mem_io_sel,
  input wire logic res_gp_fault,
  input wire logic res_form_fault,
  input wire logic res_opsize32,
  input wire logic res_addrsize32,
  // Last captured transfer
  output logic [15:0] cnt_ff,
  output logic [31:0] off_ff,
  output logic [31:0] addr_ff,
  output logic [4:0] flags_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus side latches every pulse; a pulse held too long shows as an extra count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= 16'h0;
    end
    else if (res_valid)
    begin
      cnt_ff <= cnt_ff + 16'h1;
      off_ff <= res_offset;
      addr_ff <= res_addr;
      flags_ff <= {res_mem_io_sel, res_gp_fault, res_form_fault, res_opsize32, res_addrsize32};
    end
  end
endmodule
`default_nettype wire

// ### dv/effective_address_unit_tb.sv
`default_nettype none
module effective_address_unit_tb import eau_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic req_valid, req_ready, req_io, req_use_base, req_use_index, req_opsize_pfx, req_asize_pfx;
  logic [2:0] req_base_num, req_index_num;
  logic [31:0] req_base_value, req_index_value, req_disp, req_seg_base;
  logic [1:0] req_scale;
  eau_disp_type req_disp_kind;
  logic [15:0] req_seg_sel, req_port_data_reg, m_cnt;
  logic [7:0] req_port_imm;
  logic req_port_from_reg, res_valid, res_mem_io_sel, res_gp_fault, res_form_fault;
  logic res_opsize32, res_addrsize32, irq;
  logic [31:0] res_offset, res_addr, m_off, m_addr;
  logic [4:0] m_flags;
  int n_fail, cmp_count, lat;

  eau_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .req_valid, .req_ready, .req_io, .req_use_base, .req_use_index,
    .req_base_num, .req_index_num, .req_base_value, .req_index_value, .req_scale,
    .req_disp_kind, .req_disp, .req_opsize_pfx, .req_asize_pfx, .req_seg_sel, .req_seg_base,
    .req_port_imm, .req_port_from_reg, .req_port_data_reg, .res_valid, .res_offset, .res_addr,
    .res_mem_io_sel, .res_gp_fault, .res_form_fault, .res_opsize32, .res_addrsize32, .irq);

  eau_bus_model u_bus (.aclk, .aresetn, .res_valid, .res_offset, .res_addr, .res_mem_io_sel,
    .res_gp_fault, .res_form_fault, .res_opsize32, .res_addrsize32, .cnt_ff(m_cnt),
    .off_ff(m_off), .addr_ff(m_addr), .flags_ff(m_flags));

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready is looked at just before the edge that would take the item
  task automatic wr(input string nm, input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    logic da, dw, ta, tw;
    logic [1:0] r;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge aclk);
      ta = !da && s_axi_awready === 1'b1;
      tw = !dw && s_axi_wready === 1'b1;
      @(posedge aclk);
      if (ta)
      begin
        s_axi_awvalid <= 1'b0;
        da = 1'b1;
      end
      if (tw)
      begin
        s_axi_wvalid <= 1'b0;
        dw = 1'b1;
      end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk(nm, {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [1:0] er,
      input logic [31:0] ed);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(nm, {30'h0, er}, {30'h0, r});
    chk(nm, ed, d);
  endtask

  // f packs {io, use_base, use_index, opsize prefix, address prefix}
  task automatic rq(input logic [4:0] f, input logic [2:0] bn, input logic [2:0] xn,
      input logic [31:0] bv, input logic [31:0] xv, input logic [1:0] sc,
      input eau_disp_type dk, input logic [31:0] d);
    logic [15:0] c0;
    @(posedge aclk);
    {req_io, req_use_base, req_use_index, req_opsize_pfx, req_asize_pfx} <= f;
    req_base_num <= bn;
    req_index_num <= xn;
    req_base_value <= bv;
    req_index_value <= xv;
    req_scale <= sc;
    req_disp_kind <= dk;
    req_disp <= d;
    req_valid <= 1'b1;
    do @(negedge aclk); while (req_ready !== 1'b1);
    c0 = m_cnt;
    @(posedge aclk);
    req_valid <= 1'b0;
    // Latency counts cycles from the taking edge to the cycle in which res_valid stands
    lat = 0;
    do
    begin
      @(negedge aclk);
      lat++;
    end
    while (res_valid !== 1'b1 && lat < 8);
    // Two more edges so that a pulse held one cycle too long is counted twice
    repeat (2) @(negedge aclk);
    chk("res_pulses", 32'h1, {16'h0, m_cnt - c0});
  endtask

  // Flags are {mem_io_sel, gp_fault, form_fault, opsize32, addrsize32}
  task automatic ex(input logic [31:0] eo, input logic [31:0] ea, input logic [4:0] ef,
      input int el);
    chk("res_offset", eo, m_off);
    chk("res_addr", ea, m_addr);
    chk("res_flags", {27'h0, ef}, {27'h0, m_flags});
    chk("latency", el, lat);
  endtask

  task automatic ck_irq(input logic e);
    repeat (2) @(negedge aclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    test_done();
  end

  initial
  begin
    n_fail = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
      s_axi_araddr, s_axi_wdata, s_axi_wstrb, req_valid, req_io, req_use_base, req_use_index,
      req_base_num, req_index_num, req_base_value, req_index_value, req_scale, req_disp,
      req_opsize_pfx, req_asize_pfx, req_port_imm, req_port_from_reg, req_port_data_reg} = '0;
    req_disp_kind = DISP_NONE;
    req_seg_sel = 16'h1234;
    req_seg_base = 32'h00200000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd("ctrl", OFS_CTRL, RESP_OKAY, {30'h0, CTRL_RESET});
    rd("int_en", OFS_INT_EN, RESP_OKAY, 32'h0);
    rq(5'h0c, 3'h3, 3'h7, 32'h0000fff0, 32'h00000020, 2'h3, DISP_BYTE, 32'h000000fe);
    ex(32'h0000000e, 32'h0001234e, 5'h10, 2);
    rq(5'h0b, 3'h0, 3'h0, 32'h00010000, 32'h0, 2'h0, DISP_NONE, 32'h0);
    ex(32'h00010000, 32'h00022340, 5'h1b, 1);
    rq(5'h0f, 3'h0, 3'h1, 32'h0000fff7, 32'h00000001, 2'h3, DISP_NONE, 32'h0);
    ex(32'h0000ffff, 32'h0002233f, 5'h13, 2);
    wr("ctrl", OFS_CTRL, 32'h00000002, RESP_OKAY);
    for (int s = 0; s < 4; s++)
    begin
      rq(5'h0c, 3'h0, 3'h1, 32'h00001000, 32'h00000010, s[1:0], DISP_WIDE, 32'h00000100);
      ex(32'h1100 + (32'h10 << s), 32'h201100 + (32'h10 << s), 5'h13, 2);
    end
    rq(5'h08, 3'h2, 3'h0, 32'hffffffff, 32'h0, 2'h0, DISP_BYTE, 32'h00000002);
    ex(32'h00000001, 32'h00200001, 5'h13, 1);
    rq(5'h0e, 3'h0, 3'h4, 32'h0, 32'h0, 2'h0, DISP_NONE, 32'h0);
    ex(32'h0, 32'h00200000, 5'h15, 2);
    rq(5'h0f, 3'h5, 3'h6, 32'h0001fff0, 32'h00000020, 2'h3, DISP_WIDE, 32'h00012345);
    ex(32'h00002355, 32'h00202355, 5'h10, 2);
    wr("ctrl", OFS_CTRL, 32'h0, RESP_OKAY);
    rq(5'h08, 3'h0, 3'h0, 32'h00000005, 32'h0, 2'h0, DISP_NONE, 32'h0);
    ex(32'h00000005, 32'h00200005, 5'h14, 1);
    @(posedge aclk);
    req_port_imm <= 8'hab;
    req_port_data_reg <= 16'hfffe;
    rq(5'h1c, 3'h3, 3'h7, 32'h00001234, 32'h00000010, 2'h0, DISP_WIDE, 32'h00000040);
    ex(32'h000000ab, 32'h000000ab, 5'h00, 1);
    @(posedge aclk);
    req_port_from_reg <= 1'b1;
    rq(5'h10, 3'h0, 3'h0, 32'h0, 32'h0, 2'h0, DISP_NONE, 32'h0);
    ex(32'h0000fffe, 32'h0000fffe, 5'h00, 1);
    rd("last_addr", OFS_LAST_ADDR, RESP_OKAY, 32'h0000fffe);
    rd("last_offset", OFS_LAST_OFFSET, RESP_OKAY, 32'h0000fffe);
    rd("status", OFS_STATUS, RESP_OKAY, 32'h3);
    ck_irq(1'b0);
    wr("int_en", OFS_INT_EN, 32'h2, RESP_OKAY);
    ck_irq(1'b1);
    wr("int_clr", OFS_INT_CLR, 32'h2, RESP_OKAY);
    rd("status", OFS_STATUS, RESP_OKAY, 32'h1);
    ck_irq(1'b0);
    wr("int_en", OFS_INT_EN, 32'h3, RESP_OKAY);
    ck_irq(1'b1);
    wr("int_clr", OFS_INT_CLR, 32'h1, RESP_OKAY);
    ck_irq(1'b0);
    rd("status", OFS_STATUS, RESP_OKAY, 32'h0);
    rd("int_clr", OFS_INT_CLR, RESP_OKAY, 32'h0);
    rd("unmapped", 8'h18, RESP_SLVERR, 32'h0);
    wr("unmapped", 8'h1c, 32'h3, RESP_SLVERR);
    test_done();
  end
endmodule
`default_nettype wire
